/* rtl/uhfp_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef UHFP_CONSTS_SVH
`define UHFP_CONSTS_SVH
`define UHFP_ADDR_FRAME_INDEX 8'h2c
`define UHFP_ADDR_CONFIG_FLAG 8'h60
`define UHFP_ADDR_PORT_ONE 8'h64
`define UHFP_FRAME_BITS 14
`define UHFP_CF_BIT 0
`define UHFP_PTC_LSB 16
`define UHFP_PIC_LSB 14
`define UHFP_PO_BIT 13
`define UHFP_PP_BIT 12
`define UHFP_LS_DP_BIT 11
`define UHFP_LS_DM_BIT 10
`define UHFP_PR_BIT 8
`define UHFP_SUSP_BIT 7
`define UHFP_FPR_BIT 6
`define UHFP_PED_BIT 2
`define UHFP_CSC_BIT 1
`define UHFP_CCS_BIT 0
`define UHFP_PORT_RESET 32'h00002000
`define UHFP_CLK_MHZ 200
`define UHFP_UFRAME_US 125
`define UHFP_UFRAME_CYC (`UHFP_UFRAME_US * `UHFP_CLK_MHZ)
`endif

/* rtl/uhfp_pkg.sv */
// Types shared by the frame and port register block
package uhfp_pkg;
    typedef logic [7:0] uhfp_addr_t;
    typedef logic [31:0] uhfp_word_t;
    typedef logic [13:0] uhfp_frame_t;
endpackage

/* rtl/uhfp_uframe_timer.sv */
// Microframe tick generator
`timescale 1ns/100ps
module uhfp_uframe_timer #(
    parameter int unsigned PERIOD = 25000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic run,
    output logic tick
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb
    begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!run)
        begin
            cnt_d = 32'h0;
        end
        else if (cnt_q == PERIOD - 1)
        begin
            cnt_d = 32'h0;
            tick_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule // uhfp_uframe_timer

/* rtl/uhfp_regs.sv */
// Frame index, configure flag and port one status/control registers
//
// Contract
// - 14-bit frame index in low bits, upper reserved; used as frame number
// - Frame index increments by one each microframe while running
// - Increment period is 125 us
// - Configure flag drives default port routing
// - Owner clears on flag rise, forced to one while flag is zero
// - Port register reset only by aux power-up or controller reset
// - After reset port shows no device connected and disabled
// - Port state writes ignored until port power is set
// - Line state mirrors D+ in bit 11, D- in bit 10
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "uhfp_consts.svh"
module uhfp_regs #(
    parameter int unsigned UFRAME_CYCLES = `UHFP_UFRAME_CYC
) (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hc_reset,
    // Register port
    input wire uhfp_pkg::uhfp_addr_t reg_addr,
    input wire uhfp_pkg::uhfp_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output uhfp_pkg::uhfp_word_t reg_rdata,
    // Schedule
    input wire logic run_stop_control,
    output uhfp_pkg::uhfp_frame_t frame_counter,
    output logic uframe_tick,
    // Port side
    input wire logic line_dp,
    input wire logic line_dm,
    input wire logic connect_present_in,
    output logic configured_flag,
    output logic port_owner_handoff,
    output logic port_power_bit,
    output logic port_enabled,
    output logic port_reset_bit
);
    import uhfp_pkg::*;

    uhfp_frame_t frame_q, frame_d;
    logic cf_q, cf_d;
    logic [3:0] ptc_q, ptc_d;
    logic po_q, po_d;
    logic pp_q, pp_d;
    logic [1:0] ls_q, ls_d;
    logic pr_q, pr_d;
    logic susp_q, susp_d;
    logic fpr_q, fpr_d;
    logic ped_q, ped_d;
    logic csc_q, csc_d;
    logic ccs_q, ccs_d;
    uhfp_word_t rdata_q, rdata_d;
    logic tick;
    logic port_rst;

    function automatic logic wr_hit(input uhfp_addr_t a);
        wr_hit = reg_wr && (reg_addr == a);
    endfunction

    // Power-well register only sees aux power-up and controller reset
    assign port_rst = rst || hc_reset;

    uhfp_uframe_timer #(
        .PERIOD(UFRAME_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(run_stop_control),
        .tick(tick)
    );

    // Frame index and configure flag
    always_comb
    begin
        frame_d = frame_q;
        cf_d = cf_q;
        if (wr_hit(`UHFP_ADDR_FRAME_INDEX))
        begin
            frame_d = reg_wdata[`UHFP_FRAME_BITS-1:0];
        end
        else if (tick)
        begin
            // Natural overflow gives the wrap
            frame_d = frame_q + 14'h1;
        end
        if (wr_hit(`UHFP_ADDR_CONFIG_FLAG))
        begin
            cf_d = reg_wdata[`UHFP_CF_BIT];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            frame_q <= 14'h0;
            cf_q <= 1'b0;
        end
        else
        begin
            frame_q <= frame_d;
            cf_q <= cf_d;
        end
    end

    // Port one status and control
    always_comb
    begin
        ptc_d = ptc_q;
        po_d = po_q;
        pp_d = pp_q;
        pr_d = pr_q;
        susp_d = susp_q;
        fpr_d = fpr_q;
        ped_d = ped_q;
        csc_d = csc_q;
        ls_d = {line_dp, line_dm};
        ccs_d = connect_present_in;
        if (ccs_q != connect_present_in)
        begin
            csc_d = 1'b1;
        end
        if (wr_hit(`UHFP_ADDR_PORT_ONE))
        begin
            pp_d = reg_wdata[`UHFP_PP_BIT];
            po_d = reg_wdata[`UHFP_PO_BIT];
            // State changes need power already on
            if (pp_q)
            begin
                ptc_d = reg_wdata[`UHFP_PTC_LSB+:4];
                susp_d = reg_wdata[`UHFP_SUSP_BIT];
                fpr_d = reg_wdata[`UHFP_FPR_BIT];
                ped_d = reg_wdata[`UHFP_PED_BIT];
                // Write one clears; a fresh change wins
                if (reg_wdata[`UHFP_CSC_BIT] && (ccs_q == connect_present_in))
                begin
                    csc_d = 1'b0;
                end
            end
        end
        if (!pp_q)
        begin
            ped_d = 1'b0;
        end
        // Follow the next flag value so owner never lags the flag by a cycle
        if (!cf_d)
        begin
            po_d = 1'b1;
        end
        else if (!cf_q)
        begin
            po_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (port_rst)
        begin
            ptc_q <= 4'h0;
            po_q <= 1'b1;
            pp_q <= 1'b0;
            ls_q <= 2'h0;
            pr_q <= 1'b0;
            susp_q <= 1'b0;
            fpr_q <= 1'b0;
            ped_q <= 1'b0;
            csc_q <= 1'b0;
            ccs_q <= 1'b0;
        end
        else
        begin
            ptc_q <= ptc_d;
            po_q <= po_d;
            pp_q <= pp_d;
            ls_q <= ls_d;
            pr_q <= pr_d;
            susp_q <= susp_d;
            fpr_q <= fpr_d;
            ped_q <= ped_d;
            csc_q <= csc_d;
            ccs_q <= ccs_d;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_d = 32'h0;
        if (!reg_rd)
        begin
            rdata_d = 32'h0;
        end
        else if (reg_addr == `UHFP_ADDR_FRAME_INDEX)
        begin
            rdata_d = {18'h0, frame_q};
        end
        else if (reg_addr == `UHFP_ADDR_CONFIG_FLAG)
        begin
            rdata_d = {31'h0, cf_q};
        end
        else if (reg_addr == `UHFP_ADDR_PORT_ONE)
        begin
            rdata_d[`UHFP_PO_BIT] = po_q;
            rdata_d[`UHFP_PP_BIT] = pp_q;
            rdata_d[`UHFP_LS_DP_BIT] = ls_q[1];
            rdata_d[`UHFP_LS_DM_BIT] = ls_q[0];
            // Fields except owner, power and line state read zero while unpowered
            if (pp_q)
            begin
                rdata_d[`UHFP_PTC_LSB+:4] = ptc_q;
                rdata_d[`UHFP_PR_BIT] = pr_q;
                rdata_d[`UHFP_SUSP_BIT] = susp_q;
                rdata_d[`UHFP_FPR_BIT] = fpr_q;
                rdata_d[`UHFP_PED_BIT] = ped_q;
                rdata_d[`UHFP_CSC_BIT] = csc_q;
                rdata_d[`UHFP_CCS_BIT] = ccs_q;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdata_q <= 32'h0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    logic tick_q;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= tick;
        end
    end

    assign reg_rdata = rdata_q;
    assign frame_counter = frame_q;
    assign uframe_tick = tick_q;
    assign configured_flag = cf_q;
    assign port_owner_handoff = po_q;
    assign port_power_bit = pp_q;
    assign port_enabled = ped_q;
    assign port_reset_bit = pr_q;

    a_frame_step: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && !reg_wr) |=> (frame_q == $past(frame_q) + 14'h1))
        else $error("frame index did not step");
    a_frame_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && !reg_wr && frame_q == 14'h3fff) |=> (frame_q == 14'h0))
        else $error("frame index did not wrap");
    a_frame_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (!tick && !reg_wr) |=> $stable(frame_q))
        else $error("frame index moved without tick");
    // Owner and flag change on the same edge, so no slack is allowed
    a_owner_forced: assert property (@(posedge clk_sys) disable iff (port_rst)
        (!cf_q) |-> po_q)
        else $error("owner not forced high");
    a_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == `UHFP_ADDR_CONFIG_FLAG && reg_wdata[`UHFP_CF_BIT]) |=> cf_q)
        else $error("configure flag not set by write");
    a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == `UHFP_ADDR_CONFIG_FLAG && !reg_wdata[`UHFP_CF_BIT]) |=> !cf_q)
        else $error("configure flag not cleared by write");
    a_frame_read: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == `UHFP_ADDR_FRAME_INDEX) |=> (reg_rdata == {18'h0, $past(frame_q)}))
        else $error("frame index read wrong");
    a_line_read: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == `UHFP_ADDR_PORT_ONE) |=> (reg_rdata[`UHFP_LS_DP_BIT:`UHFP_LS_DM_BIT] == $past(ls_q)))
        else $error("line state read wrong");
    a_owner_rise: assert property (@(posedge clk_sys) disable iff (port_rst)
        ($rose(cf_q)) |-> !po_q)
        else $error("owner not cleared on flag rise");
    a_unpowered_hold: assert property (@(posedge clk_sys) disable iff (port_rst)
        (!pp_q) |=> (ptc_q == $past(ptc_q)) && !ped_q)
        else $error("port state changed unpowered");
    a_line_mirror: assert property (@(posedge clk_sys) disable iff (port_rst)
        1'b1 |=> (ls_q == {$past(line_dp), $past(line_dm)}))
        else $error("line state not mirrored");
    a_reset_state: assert property (@(posedge clk_sys)
        port_rst |=> (!ccs_q && !ped_q && po_q))
        else $error("port reset state wrong");
endmodule // uhfp_regs

/* sim/uhfp_dev_model.sv */
// Peripheral model on the downstream port
`timescale 1ns/100ps
module uhfp_dev_model (
    // Clock
    input wire logic clk_sys,
    // Test control
    input wire logic attach,
    input wire logic k_state,
    // Bus lines
    output logic line_dp,
    output logic line_dm,
    output logic present
);
    initial
    begin
        line_dp = 1'b0;
        line_dm = 1'b0;
        present = 1'b0;
    end
    // Detached lines sit at the host pull-downs, never the last level
    always @(posedge clk_sys)
    begin
        present <= attach;
        line_dp <= attach & ~k_state;
        line_dm <= attach & k_state;
    end
endmodule // uhfp_dev_model

/* sim/test_uhfp_regs.sv */
// Testbench for the frame and port register block
`timescale 1ns/100ps
module test_uhfp_regs;
    import uhfp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hc_reset = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run = 1'b0;
    logic attach = 1'b0;
    logic k_state = 1'b0;
    uhfp_addr_t reg_addr = 8'h00;
    uhfp_word_t reg_wdata = 32'h0;
    uhfp_word_t reg_rdata;
    uhfp_word_t saved;
    uhfp_frame_t frame_counter;
    logic uframe_tick, configured_flag, port_owner_handoff, port_power_bit;
    logic port_enabled, port_reset_bit, line_dp, line_dm, present;
    int n_mismatch = 0;
    int n_compared = 0;
    int gap;

    always #2.5 clk_sys = ~clk_sys;

    // Short microframe keeps the run brief
    uhfp_regs #(.UFRAME_CYCLES(20)) dut_u (.clk_sys(clk_sys), .rst(rst), .hc_reset(hc_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .run_stop_control(run), .frame_counter(frame_counter),
        .uframe_tick(uframe_tick), .line_dp(line_dp), .line_dm(line_dm),
        .connect_present_in(present), .configured_flag(configured_flag),
        .port_owner_handoff(port_owner_handoff), .port_power_bit(port_power_bit),
        .port_enabled(port_enabled), .port_reset_bit(port_reset_bit));

    uhfp_dev_model dev_u (.clk_sys(clk_sys), .attach(attach), .k_state(k_state),
        .line_dp(line_dp), .line_dm(line_dm), .present(present));

    task automatic chk(input string what, input uhfp_word_t exp, input uhfp_word_t got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input uhfp_addr_t a, input uhfp_word_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input uhfp_addr_t a, input uhfp_word_t exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    task automatic wait_tick;
        gap = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            gap++;
        end
        while (uframe_tick !== 1'b1 && gap < 100);
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Tests need well under a thousand cycles
    initial
    begin
        #50000;
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk("frame", 8'h2c, 32'h0);
        rd_chk("flag", 8'h60, 32'h0);
        rd_chk("port", 8'h64, 32'h00002000);
        rd_chk("unmapped", 8'h30, 32'h0);
        $display("test reset done");
        wr(8'h2c, 32'h00003ffe);
        rd_chk("frame write", 8'h2c, 32'h00003ffe);
        @(posedge clk_sys);
        run <= 1'b1;
        wait_tick();
        chk("frame step", 32'h3fff, {18'h0, frame_counter});
        wait_tick();
        chk("tick gap", 32'd20, gap);
        chk("frame wrap", 32'h0, {18'h0, frame_counter});
        @(posedge clk_sys);
        run <= 1'b0;
        $display("test frame done");
        wr(8'h60, 32'h1);
        rd_chk("flag set", 8'h60, 32'h1);
        chk("flag out", 32'h1, {31'h0, configured_flag});
        chk("owner clear", 32'h0, {31'h0, port_owner_handoff});
        wr(8'h60, 32'h0);
        rd_chk("flag clear", 8'h60, 32'h0);
        chk("flag out low", 32'h0, {31'h0, configured_flag});
        chk("owner forced", 32'h1, {31'h0, port_owner_handoff});
        $display("test flag done");
        wr(8'h64, 32'h00000004);
        chk("enable unpowered", 32'h0, {31'h0, port_enabled});
        wr(8'h64, 32'h00001000);
        wr(8'h64, 32'h00001004);
        chk("enable powered", 32'h1, {31'h0, port_enabled});
        @(posedge clk_sys);
        attach <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk("port j", 8'h64, 32'h00003807);
        @(posedge clk_sys);
        k_state <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk("port k", 8'h64, 32'h00003407);
        wr(8'h64, 32'h00001006);
        rd_chk("change clear", 8'h64, 32'h00003405);
        wr(8'h64, 32'h000310c4);
        rd_chk("port test", 8'h64, 32'h000334c5);
        $display("test port done");
        saved = {18'h0, frame_counter};
        @(posedge clk_sys);
        hc_reset <= 1'b1;
        @(posedge clk_sys);
        hc_reset <= 1'b0;
        rd_chk("port hc reset", 8'h64, 32'h00002400);
        chk("power hc reset", 32'h0, {31'h0, port_power_bit});
        chk("reset bit", 32'h0, {31'h0, port_reset_bit});
        chk("enable hc reset", 32'h0, {31'h0, port_enabled});
        chk("frame kept", saved, {18'h0, frame_counter});
        $display("test controller reset done");
        print_verdict();
    end
endmodule // test_uhfp_regs
